// >>> logic/chmove_pkg.sv
// Shared constants and carriers for the channel move and flow add logic
`default_nettype none
package chmove_pkg;
    localparam int          CH_W             = 8;
    localparam logic [7:0]  TLV_RANGING_TYPE = 8'h01;
    localparam logic [7:0]  TLV_RANGING_LEN  = 8'h01;
    localparam logic [7:0]  TLV_QOS_TYPE     = 8'h02;
    localparam logic [7:0]  TLV_CLASS_TYPE   = 8'h03;
    localparam logic [7:0]  TLV_HDRS_TYPE    = 8'h04;
    localparam logic [7:0]  TLV_SCNAME_TYPE  = 8'h05;
    localparam logic [7:0]  TLV_KEYSEQ_TYPE  = 8'h06;
    localparam logic [7:0]  TLV_DIGEST_TYPE  = 8'h07;
    localparam logic [7:0]  TLV_FREF_TYPE    = 8'h08;
    localparam logic [7:0]  TLV_CREF_TYPE    = 8'h09;
    localparam logic [7:0]  RNG_INITIAL      = 8'h00;
    localparam logic [7:0]  RNG_STATION      = 8'h01;
    localparam logic [7:0]  RNG_EITHER       = 8'h02;
    localparam logic [7:0]  RNG_DIRECT       = 8'h03;
    localparam logic [7:0]  RESET_CHANNEL    = 8'h00;
    localparam logic [15:0] RESET_TRANS_ID   = 16'h0001;
    localparam logic [7:0]  FLOW_REF_UP      = 8'h01;
    localparam logic [7:0]  FLOW_REF_DOWN    = 8'h02;
    localparam logic [7:0]  CLASS_REF_BASE   = 8'h01;
    localparam logic [7:0]  LEN_ONE          = 8'h01;
    localparam logic [7:0]  LEN_TWO          = 8'h02;

    typedef enum logic [1:0] {
        RANGE_INITIAL,
        RANGE_STATION,
        RANGE_NONE
    } range_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
    } byte_beat_t;

    typedef struct packed {
        logic       want_up;
        logic       want_down;
        logic       with_class;
        logic       with_hdrs;
        logic       use_scname;
        logic       privacy;
        logic [7:0] key_seq;
    } flow_add_cmd_t;
endpackage : chmove_pkg
`default_nettype wire

// >>> logic/tlv_emit.sv
// One-tuple emitter: type, length, then up to two value octets
`timescale 1ns/100ps
`default_nettype none
module tlv_emit (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic       start,
    input  wire logic [7:0] tlv_type,
    input  wire logic [7:0] tlv_len,
    input  wire logic [15:0] value,
    input  wire logic       beat_ready,
    output logic            beat_valid,
    output logic [7:0]      beat_data,
    output logic            done
);
    logic [1:0] idx_reg;
    logic [1:0] idx_next;
    logic       busy_reg;
    wire  logic [1:0] last_idx = (tlv_len == chmove_pkg::LEN_TWO) ? 2'h3
                                                                  : 2'h2;
    wire  logic step = busy_reg && beat_ready;

    assign beat_valid = busy_reg;
    // Type and length are single octets
    // one octet fields
    assign beat_data  = (idx_reg == 2'h0) ? tlv_type :
                        (idx_reg == 2'h1) ? tlv_len  :
                        (idx_reg == 2'h2 && last_idx == 2'h3) ? value[15:8]
                                                              : value[7:0];
    assign done       = step && (idx_reg == last_idx);
    assign idx_next   = done ? 2'h0 : idx_reg + 2'h1;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            idx_reg  <= 2'h0;
            busy_reg <= 1'b0;
        end else if (clk_en) begin
            if (start && !busy_reg) busy_reg <= 1'b1;
            else if (done) busy_reg <= 1'b0;
            if (step) idx_reg <= idx_next;
        end
    end
endmodule // tlv_emit
`default_nettype wire

// >>> logic/chmove_flowadd.sv
// Subscriber modem channel move handler and flow add request builder
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module chmove_flowadd (
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic                     clk_en,
    input  wire chmove_pkg::byte_beat_t   rx_beat,
    input  wire logic                     rx_valid,
    input  wire logic                     tx_ready,
    output logic                          tx_valid,
    output chmove_pkg::byte_beat_t        tx_beat,
    output logic                          reply_busy,
    input  wire logic                     switch_done,
    input  wire logic                     range_done,
    output logic [7:0]                    active_channel,
    output chmove_pkg::range_mode_t       range_mode,
    output logic                          switch_req,
    output logic                          range_req,
    output logic                          range_broadcast,
    output logic                          change_busy,
    input  wire logic                     prefer_station,
    input  wire logic                     fa_start,
    input  wire chmove_pkg::flow_add_cmd_t fa_cmd,
    input  wire logic [7:0]               digest_byte,
    output logic                          fa_busy,
    output logic [15:0]                   fa_trans_id
);
    typedef enum logic [1:0] { RX_CHAN, RX_TYPE, RX_LEN, RX_VAL } rx_t;
    typedef enum logic [2:0] {
        CH_IDLE, CH_REPLY, CH_SWITCH, CH_RANGE
    } ch_t;
    typedef enum logic [3:0] {
        FA_IDLE, FA_TID_H, FA_TID_L, FA_UP, FA_UPQ, FA_DOWN, FA_DNQ,
        FA_CLASS, FA_HDRS, FA_KEY, FA_DIGEST
    } fa_t;

    ////////////////////////////////////////////////////////////////////////
    // Request parser
    rx_t         rx_reg;
    logic [7:0]  tgt_reg;
    logic [7:0]  ttype_reg;
    logic [7:0]  tlen_reg;
    logic [7:0]  rng_reg;
    logic        rng_seen_reg;
    logic        req_done;
    ch_t         ch_reg;
    logic [7:0]  chan_reg;
    logic [7:0]  reply_chan_reg;
    logic        same_reg;
    chmove_pkg::range_mode_t mode_reg;
    logic        rx_take;

    assign rx_take  = rx_valid && clk_en && (ch_reg == CH_IDLE);
    assign req_done = rx_take && rx_beat.last;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_reg       <= RX_CHAN;
            tgt_reg      <= 8'h00;
            ttype_reg    <= 8'h00;
            tlen_reg     <= 8'h00;
            rng_reg      <= 8'h00;
            rng_seen_reg <= 1'b0;
        end else if (rx_take) begin
            case (rx_reg)
                RX_CHAN: begin
                    tgt_reg      <= rx_beat.data;
                    rng_seen_reg <= 1'b0;
                    rx_reg       <= RX_TYPE;
                end
                RX_TYPE: begin
                    ttype_reg <= rx_beat.data;
                    rx_reg    <= RX_LEN;
                end
                RX_LEN: begin
                    tlen_reg <= rx_beat.data;
                    rx_reg   <= (rx_beat.data == 8'h00) ? RX_TYPE : RX_VAL;
                end
                RX_VAL: begin
                    if (ttype_reg == chmove_pkg::TLV_RANGING_TYPE &&
                        tlen_reg == chmove_pkg::TLV_RANGING_LEN) begin
                        rng_reg      <= rx_beat.data;
                        rng_seen_reg <= 1'b1;
                    end
                    tlen_reg <= tlen_reg - 8'h01;
                    if (tlen_reg == 8'h01) rx_reg <= RX_TYPE;
                end
                default: rx_reg <= RX_CHAN;
            endcase
            if (rx_beat.last) rx_reg <= RX_CHAN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ranging choice
    logic        rng_final;
    logic [7:0]  rng_val;
    chmove_pkg::range_mode_t mode_sel;
    // Last beat may itself hold the ranging value
    assign rng_final = (rx_reg == RX_VAL) &&
                       ttype_reg == chmove_pkg::TLV_RANGING_TYPE &&
                       tlen_reg == chmove_pkg::TLV_RANGING_LEN;
    assign rng_val   = rng_final ? rx_beat.data : rng_reg;
    assign mode_sel  = !(rng_final || (rng_seen_reg && rx_reg != RX_CHAN))
                       ? chmove_pkg::RANGE_INITIAL :
        rng_val == chmove_pkg::RNG_STATION ? chmove_pkg::RANGE_STATION :
        rng_val == chmove_pkg::RNG_DIRECT  ? chmove_pkg::RANGE_NONE :
        (rng_val == chmove_pkg::RNG_EITHER && prefer_station)
                                           ? chmove_pkg::RANGE_STATION
                                           : chmove_pkg::RANGE_INITIAL;

    ////////////////////////////////////////////////////////////////////////
    // Channel change sequencer
    logic       ch_valid;
    logic [7:0] ch_data;
    logic       ch_done;
    logic       ch_ready;
    logic       ch_first_reg;
    logic [7:0] req_chan;
    assign req_chan = (rx_reg == RX_CHAN) ? rx_beat.data : tgt_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ch_reg         <= CH_IDLE;
            chan_reg       <= chmove_pkg::RESET_CHANNEL;
            reply_chan_reg <= chmove_pkg::RESET_CHANNEL;
            same_reg       <= 1'b0;
            mode_reg       <= chmove_pkg::RANGE_INITIAL;
            ch_first_reg   <= 1'b0;
        end else if (clk_en) begin
            case (ch_reg)
                CH_IDLE: if (req_done) begin
                    reply_chan_reg <= req_chan;
                    same_reg       <= (req_chan == chan_reg);
                    mode_reg       <= mode_sel;
                    ch_first_reg   <= 1'b1;
                    ch_reg         <= CH_REPLY;
                end
                CH_REPLY: begin
                    if (ch_valid && ch_ready) ch_first_reg <= 1'b0;
                    if (ch_done) ch_reg <= same_reg ? CH_IDLE : CH_SWITCH;
                end
                CH_SWITCH: if (switch_done) begin
                    chan_reg <= reply_chan_reg;
                    ch_reg   <= (mode_reg == chmove_pkg::RANGE_NONE) ?
                                CH_IDLE : CH_RANGE;
                end
                CH_RANGE: if (range_done) ch_reg <= CH_IDLE;
                default: ch_reg <= CH_IDLE;
            endcase
        end
    end

    // Reply is the channel byte alone
    assign ch_valid      = (ch_reg == CH_REPLY);
    assign ch_data       = reply_chan_reg;
    assign ch_done       = ch_valid && ch_ready;
    assign switch_req    = (ch_reg == CH_SWITCH);
    assign range_req     = (ch_reg == CH_RANGE);
    assign range_broadcast = (ch_reg == CH_RANGE);
    assign range_mode    = mode_reg;
    assign change_busy   = (ch_reg != CH_IDLE);
    assign active_channel = chan_reg;
    assign reply_busy    = ch_valid;

    ////////////////////////////////////////////////////////////////////////
    // Flow add request builder
    fa_t           fa_reg;
    fa_t           fa_next;
    chmove_pkg::flow_add_cmd_t cmd_reg;
    logic [15:0]   tid_reg;
    logic          fa_first_reg;
    logic          t_start;
    logic [7:0]    t_type;
    logic [7:0]    t_len;
    logic [15:0]   t_val;
    logic          t_valid;
    logic [7:0]    t_data;
    logic          t_done;
    logic          fa_beat;
    logic          fa_hold_reg;

    wire logic fa_ok = fa_cmd.want_up || fa_cmd.want_down;
    wire logic in_tlv = (fa_reg != FA_IDLE) && (fa_reg != FA_TID_H) &&
                        (fa_reg != FA_TID_L);

    // Step through optional tuples; digest comes last when privacy is set
    // digest final
    always_comb begin
        fa_next = FA_IDLE;
        case (fa_reg)
            FA_TID_L:  fa_next = cmd_reg.want_up ? FA_UP : FA_DOWN;
            FA_UP:     fa_next = FA_UPQ;
            FA_UPQ:    fa_next = cmd_reg.want_down  ? FA_DOWN :
                                 cmd_reg.with_class ? FA_CLASS :
                                 cmd_reg.with_hdrs  ? FA_HDRS :
                                 cmd_reg.privacy    ? FA_KEY : FA_IDLE;
            FA_DOWN:   fa_next = FA_DNQ;
            FA_DNQ:    fa_next = cmd_reg.with_class ? FA_CLASS :
                                 cmd_reg.with_hdrs  ? FA_HDRS :
                                 cmd_reg.privacy    ? FA_KEY : FA_IDLE;
            FA_CLASS:  fa_next = cmd_reg.with_hdrs  ? FA_HDRS :
                                 cmd_reg.privacy    ? FA_KEY : FA_IDLE;
            FA_HDRS:   fa_next = cmd_reg.privacy ? FA_KEY : FA_IDLE;
            FA_KEY:    fa_next = FA_DIGEST;
            default:   fa_next = FA_IDLE;
        endcase
    end

    assign t_type = (fa_reg == FA_UP || fa_reg == FA_DOWN) ?
                        chmove_pkg::TLV_FREF_TYPE :
                    (fa_reg == FA_UPQ || fa_reg == FA_DNQ) ?
                        (cmd_reg.use_scname ? chmove_pkg::TLV_SCNAME_TYPE
                                            : chmove_pkg::TLV_QOS_TYPE) :
                    (fa_reg == FA_CLASS)  ? chmove_pkg::TLV_CREF_TYPE :
                    (fa_reg == FA_HDRS)   ? chmove_pkg::TLV_HDRS_TYPE :
                    (fa_reg == FA_KEY)    ? chmove_pkg::TLV_KEYSEQ_TYPE
                                          : chmove_pkg::TLV_DIGEST_TYPE;
    assign t_len  = (fa_reg == FA_HDRS) ? chmove_pkg::LEN_TWO
                                        : chmove_pkg::LEN_ONE;
    assign t_val  = (fa_reg == FA_UP || fa_reg == FA_UPQ) ?
                        {8'h00, chmove_pkg::FLOW_REF_UP} :
                    (fa_reg == FA_DOWN || fa_reg == FA_DNQ) ?
                        {8'h00, chmove_pkg::FLOW_REF_DOWN} :
                    (fa_reg == FA_CLASS) ? {8'h00, chmove_pkg::CLASS_REF_BASE} :
                    (fa_reg == FA_HDRS)  ? {chmove_pkg::CLASS_REF_BASE,
                                            cmd_reg.want_up ?
                                            chmove_pkg::FLOW_REF_UP :
                                            chmove_pkg::FLOW_REF_DOWN} :
                    (fa_reg == FA_KEY)   ? {8'h00, cmd_reg.key_seq}
                                         : {8'h00, digest_byte};
    assign t_start = in_tlv && !fa_hold_reg;

    tlv_emit u_emit (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .start      (t_start),
        .tlv_type   (t_type),
        .tlv_len    (t_len),
        .value      (t_val),
        .beat_ready (tx_ready && !ch_valid),
        .beat_valid (t_valid),
        .beat_data  (t_data),
        .done       (t_done)
    );

    wire logic tid_beat = (fa_reg == FA_TID_H || fa_reg == FA_TID_L) &&
                          !ch_valid && tx_ready && clk_en;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fa_reg       <= FA_IDLE;
            cmd_reg      <= '0;
            tid_reg      <= chmove_pkg::RESET_TRANS_ID;
            fa_first_reg <= 1'b0;
            fa_hold_reg  <= 1'b0;
        end else if (clk_en) begin
            if (fa_reg == FA_IDLE && fa_start && fa_ok) begin
                cmd_reg      <= fa_cmd;
                fa_first_reg <= 1'b1;
                fa_reg       <= FA_TID_H;
            end else if (fa_reg == FA_TID_H && tid_beat) begin
                fa_first_reg <= 1'b0;
                fa_reg       <= FA_TID_L;
            end else if (fa_reg == FA_TID_L && tid_beat) begin
                fa_reg <= fa_next;
            end else if (in_tlv) begin
                fa_hold_reg <= !t_done;
                if (t_done) begin
                    fa_reg <= fa_next;
                    if (fa_next == FA_IDLE) tid_reg <= tid_reg + 16'h0001;
                end
            end
        end
    end

    assign fa_beat     = (fa_reg == FA_TID_H || fa_reg == FA_TID_L) || t_valid;
    assign fa_busy     = (fa_reg != FA_IDLE);
    assign fa_trans_id = tid_reg;

    // Channel reply wins the port; flow add waits a beat
    assign tx_valid      = ch_valid || fa_beat;
    wire logic [7:0] tx_data = ch_valid ? ch_data :
                               (fa_reg == FA_TID_H) ? tid_reg[15:8] :
                               (fa_reg == FA_TID_L) ? tid_reg[7:0] : t_data;
    wire logic tx_first = ch_valid ? ch_first_reg : fa_first_reg;
    wire logic tx_last  = ch_valid || (t_done && (fa_next == FA_IDLE));
    assign tx_beat       = {tx_data, tx_first, tx_last};
    assign ch_ready      = tx_ready;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // echo check
    chk_reply_echo: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en && ch_reg == CH_IDLE && req_done)
        |=> (tx_valid && tx_beat.data == $past(req_chan)))
        else $error("reply channel differs from request");
    chk_switch_order: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(switch_req) |-> $past(ch_reg == CH_REPLY))
        else $error("switch started without reply");
    chk_range_default: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en && req_done && (rx_reg == RX_CHAN || (!rng_final
         && !rng_seen_reg))) |=> (range_mode == chmove_pkg::RANGE_INITIAL))
        else $error("absent ranging did not pick initial");
    chk_range_big: assert property (@(posedge mclk) disable iff (sys_rst)
        (clk_en && ch_reg == CH_IDLE && req_done && rng_val > 8'h03)
        |=> (range_mode == chmove_pkg::RANGE_INITIAL))
        else $error("bad ranging value not initial");
    chk_same_chan: assert property (@(posedge mclk) disable iff (sys_rst)
        (ch_reg == CH_REPLY && same_reg && ch_done && clk_en)
        |=> (ch_reg == CH_IDLE))
        else $error("same channel request caused a switch");
    chk_rerange: assert property (@(posedge mclk) disable iff (sys_rst)
        (ch_reg == CH_SWITCH && switch_done && clk_en && mode_reg
         != chmove_pkg::RANGE_NONE) |=> (range_req && range_broadcast))
        else $error("no broadcast ranging after switch");
    chk_ignore_busy: assert property (@(posedge mclk) disable iff (sys_rst)
        (change_busy && rx_valid) |=> ($stable(tgt_reg) && $stable(rx_reg)))
        else $error("request taken during change");
    chk_digest_last: assert property (@(posedge mclk) disable iff (sys_rst)
        (tx_valid && tx_beat.last && !ch_valid && cmd_reg.privacy)
        |-> (fa_reg == FA_DIGEST))
        else $error("digest not final attribute");
endmodule // chmove_flowadd
`default_nettype wire

// >>> test/headend_model.sv
// Head-end stand-in: request sender, reply sink, channel PHY answers
`timescale 1ns/100ps
`default_nettype none
module headend_model (
    input  wire logic              mclk,
    input  wire logic              hold,
    input  wire logic              switch_req,
    input  wire logic              range_req,
    output chmove_pkg::byte_beat_t rx_beat,
    output logic                   rx_valid,
    output logic                   tx_ready,
    output logic                   switch_done,
    output logic                   range_done
);
    logic [2:0] wait_cnt = 3'h0;
    assign tx_ready = !hold;
    initial begin
        rx_valid = 1'b0;
        rx_beat = '{8'h5A, 1'b0, 1'b0};
        switch_done = 1'b0;
        range_done = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // channel octet, one-octet type and length
    task automatic send_req(input logic [7:0] ch, input logic has,
                            input logic [7:0] v);
        @(negedge mclk);
        rx_valid = 1'b1;
        rx_beat = '{ch, 1'b1, !has};
        if (has) begin
            @(negedge mclk);
            rx_beat = '{chmove_pkg::TLV_RANGING_TYPE, 1'b0, 1'b0};
            @(negedge mclk);
            rx_beat = '{chmove_pkg::TLV_RANGING_LEN, 1'b0, 1'b0};
            @(negedge mclk);
            rx_beat = '{v, 1'b0, 1'b1};
        end
        @(negedge mclk);
        rx_valid = 1'b0;
        // Stale byte inverted so it never reads as the last one
        rx_beat = '{~rx_beat.data, 1'b0, 1'b0};
    endtask
    ////////////////////////////////////////////////////////////////////////
    // ranging accepted whatever mode the modem picked
    // model sends no flow additions of its own
    always @(negedge mclk) begin
        wait_cnt <= (switch_req | range_req) ? wait_cnt + 3'h1 : 3'h0;
        switch_done <= switch_req && wait_cnt == 3'h5;
        range_done <= range_req && wait_cnt == 3'h5;
    end
endmodule // headend_model
`default_nettype wire

// >>> test/chmove_flowadd_test.sv
// Self-checking bench for the channel move and flow add logic
`timescale 1ns/100ps
`default_nettype none
module chmove_flowadd_test;
    logic                      mclk = 1'b0;
    logic                      sys_rst = 1'b1;
    logic                      hold = 1'b0;
    logic                      clk_en = 1'b1;
    logic                      prefer_station = 1'b0;
    logic                      fa_start = 1'b0;
    chmove_pkg::flow_add_cmd_t fa_cmd = '0;
    logic [7:0]                digest_byte = 8'h00;
    chmove_pkg::byte_beat_t    rx_beat, tx_beat;
    chmove_pkg::range_mode_t   range_mode;
    logic                      rx_valid, tx_ready, tx_valid, reply_busy;
    logic                      switch_done, range_done, switch_req;
    logic                      range_req, range_broadcast, change_busy;
    logic                      fa_busy;
    logic [7:0]                active_channel;
    logic [15:0]               fa_trans_id, tid;
    logic [31:0]               seed = 32'hD081;
    logic [7:0]                vals [7] = '{8'h00, 8'h02, 8'h02, 8'h03,
                                            8'h09, 8'h01, 8'h00};
    int                        n_errors = 0, samples_checked = 0;
    int                        cycles = 0;
    chmove_pkg::byte_beat_t    q [$];

    always #5 mclk = ~mclk;

    chmove_flowadd DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .rx_beat(rx_beat), .rx_valid(rx_valid), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_beat(tx_beat), .reply_busy(reply_busy),
        .switch_done(switch_done), .range_done(range_done),
        .active_channel(active_channel), .range_mode(range_mode),
        .switch_req(switch_req), .range_req(range_req),
        .range_broadcast(range_broadcast), .change_busy(change_busy),
        .prefer_station(prefer_station), .fa_start(fa_start),
        .fa_cmd(fa_cmd), .digest_byte(digest_byte), .fa_busy(fa_busy),
        .fa_trans_id(fa_trans_id));
    headend_model hm (.mclk(mclk), .hold(hold), .switch_req(switch_req),
        .range_req(range_req), .rx_beat(rx_beat), .rx_valid(rx_valid),
        .tx_ready(tx_ready), .switch_done(switch_done),
        .range_done(range_done));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] exp_mode(input logic h, input logic [7:0] v,
                                            input logic ps);
        if (h && (v == 8'h01 || (v == 8'h02 && ps)))
            return chmove_pkg::RANGE_STATION;
        if (h && v == 8'h03)
            return chmove_pkg::RANGE_NONE;
        return chmove_pkg::RANGE_INITIAL;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (tx_valid && tx_ready && clk_en && !sys_rst)
            q.push_back(tx_beat);
        // Ceiling well above the few hundred cycles the tests need
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    always @(negedge mclk) begin
        if (!sys_rst) begin
            check(16'(tx_valid & switch_req), 16'h0);
            if (range_req)
                check(16'(range_broadcast), 16'h1);
        end
    end
    task automatic move(input logic [7:0] ch, input logic h,
                        input logic [7:0] v);
        logic [7:0] old;
        old = active_channel;
        q.delete();
        seed = lfsr(seed);
        prefer_station = seed[0];
        hold = seed[1];
        hm.send_req(ch, h, v);
        repeat (3) @(negedge mclk);
        hold = 1'b0;
        for (int i = 0; i < 200 && q.size() == 0; i++) @(negedge mclk);
        check(16'(q.size()), 16'h1);
        check({q[0].data, q[0].first, q[0].last}, {ch, 2'b11});
        if (ch == old)
            check(16'(switch_req | change_busy), 16'h0);
        for (int i = 0; i < 300 && change_busy; i++) @(negedge mclk);
        check(active_channel, ch);
        if (ch != old)
            check(range_mode, exp_mode(h, v, prefer_station));
        $display("move to %h done", ch);
    endtask
    task automatic flow_add();
        int i, nref, nqos;
        logic [7:0] lt;
        q.delete();
        tid = fa_trans_id;
        seed = lfsr(seed);
        digest_byte = seed[15:8];
        fa_cmd = '{seed[0], !seed[0] | seed[1], seed[2], seed[3], seed[4],
                   seed[5], seed[23:16]};
        fa_start = 1'b1;
        @(negedge mclk);
        fa_start = 1'b0;
        for (i = 0; i < 300 && !(q.size() > 0 && q[$].last); i++) begin
            @(negedge mclk);
            seed = lfsr(seed);
            hold = seed[0];
            clk_en = seed[1] | seed[2];
        end
        hold = 1'b0;
        clk_en = 1'b1;
        check({q[0].data, q[1].data}, tid);
        check(fa_trans_id, tid + 16'h1);
        nref = 0;
        nqos = 0;
        for (i = 2; i + 1 < q.size(); i += 2 + int'(q[i + 1].data)) begin
            nref += int'(q[i].data == chmove_pkg::TLV_FREF_TYPE);
            nqos += int'(q[i].data == (fa_cmd.use_scname ?
                chmove_pkg::TLV_SCNAME_TYPE : chmove_pkg::TLV_QOS_TYPE));
            lt = q[i].data;
        end
        check(16'(nref), 16'(fa_cmd.want_up) + 16'(fa_cmd.want_down));
        check(16'(nqos > 0), 16'h1);
        check(16'(nqos), 16'(nref));
        check(16'(i), 16'(q.size()));
        if (fa_cmd.privacy)
            check({lt, q[$].data}, {chmove_pkg::TLV_DIGEST_TYPE, digest_byte});
        $display("flow add %h done", tid);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        check({tx_valid, change_busy, fa_busy, reply_busy}, 16'h0);
        check(active_channel, chmove_pkg::RESET_CHANNEL);
        check(fa_trans_id, chmove_pkg::RESET_TRANS_ID);
        for (int v = 0; v < 7; v++) begin
            seed = lfsr(seed);
            move(seed[23:16] | 8'h01, v != 6, vals[v]);
        end
        move(active_channel, 1'b0, 8'h00);
        q.delete();
        hm.send_req(8'h32, 1'b0, 8'h00);
        for (int i = 0; i < 50 && !switch_req; i++) @(negedge mclk);
        hm.send_req(8'h44, 1'b0, 8'h00);
        for (int i = 0; i < 300 && change_busy; i++) @(negedge mclk);
        check({16'(q.size()), active_channel}, {16'h1, 8'h32});
        $display("busy drop done");
        for (int k = 0; k < 6; k++)
            flow_add();
        give_verdict();
    end
endmodule // chmove_flowadd_test
`default_nettype wire
